// ### rtl/keypad_menu_controller.v
// Keypad menu controller: four debounced front keys drive the setup,
// fast preset access and normal operation levels over a parameter store.
// Keys are synchronous to ref_clk; operating logic reads cfgAddr/cfgData
// and reloads its settings on applyPulse.
`timescale 1ns/1ps
`default_nettype none
`include "keypad_menu_regs.vh"

module keypad_menu_controller #(
    parameter        DIGITS        = 6,
    parameter [27:0] DEB_CYC       = `DEBOUNCE_MS * `CLK_KHZ,
    parameter [27:0] LONG_CYC      = `LONG_PRESS_MS * `CLK_KHZ,
    parameter [27:0] TIMEOUT_CYC   = `TIMEOUT_MS * `CLK_KHZ,
    parameter [27:0] CODE_HOLD_CYC = `CODE_HOLD_MS * `CLK_KHZ,
    parameter [27:0] VERDICT_CYC   = `VERDICT_MS * `CLK_KHZ
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        programKey,
    input  wire        upKey,
    input  wire        downKey,
    input  wire        enterKey,
    input  wire [7:0]  cfgAddr,
    output wire [31:0] cfgData,
    output wire        evalEnable,
    output wire        applyPulse,
    output wire        fastMode,
    output wire        keyCmdValid,
    output wire [1:0]  keyCmdSel,
    output wire [7:0]  keyCmdFunc,
    output reg  [2:0]  dispMode,
    output wire [3:0]  dispGroup,
    output wire [7:0]  dispParam,
    output wire [31:0] dispValue,
    output wire [2:0]  cursorPos
);
    localparam integer DIGITS_M1 = DIGITS - 1;
    localparam [2:0]   LEFT_POS  = DIGITS_M1[2:0];

    reg  [1:0]  rstPipe_reg;
    wire        rstSync_n;
    wire [3:0]  keyRaw;
    wire [3:0]  keyLvl;
    reg  [3:0]  keyPrev_reg;
    wire [3:0]  keyPress;
    wire        pressProg;
    wire        pressUp;
    wire        pressDown;
    wire        pressEnter;
    wire        anyPress;

    reg  [2:0]  state_reg;
    reg  [3:0]  group_reg;
    reg  [7:0]  param_reg;
    reg  [31:0] editVal_reg;
    reg  [2:0]  cursor_reg;
    reg         fast_reg;
    reg  [27:0] idle_reg;
    reg  [27:0] hold_reg;
    reg         verdictOk_reg;
    reg         apply_reg;
    reg         cmdValid_reg;
    reg  [1:0]  cmdSel_reg;
    reg  [7:0]  cmdFunc_reg;
    reg  [7:0]  fnUpPend_reg;
    reg  [7:0]  fnDnPend_reg;
    reg  [7:0]  fnEnPend_reg;
    reg  [7:0]  fnUpAct_reg;
    reg  [7:0]  fnDnAct_reg;
    reg  [7:0]  fnEnAct_reg;

    wire [7:0]  rdAddr;
    wire [31:0] rdData;
    wire [15:0] span;
    wire [15:0] presetSpan;
    wire        menuOpen;
    wire        timeout;
    wire        upStep;
    wire        editAllowed;
    wire        storeNow;
    wire [31:0] shifted;
    wire [3:0]  curDigit;
    wire        signedDigit;
    wire [3:0]  digitTop;
    wire [3:0]  digitUp;
    wire [3:0]  digitDown;
    wire [4:0]  shiftAmt;
    wire [31:0] digitMask;
    wire [31:0] valUp;
    wire [31:0] valDown;
    wire [2:0]  cursorLeft;

    // Reset release through two flip-flops
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_reg <= 2'b00;
        end else begin
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_reg[1];

    // Per-key debounce: level follows raw input once stable
    assign keyRaw = {enterKey, downKey, upKey, programKey};
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : gDeb
            reg [27:0] cnt_reg;
            reg        lvl_reg;
            always @(posedge ref_clk or negedge rstSync_n) begin
                if (!rstSync_n) begin
                    cnt_reg <= 28'h0;
                    lvl_reg <= 1'b0;
                end else if (keyRaw[i] == lvl_reg) begin
                    cnt_reg <= 28'h0;
                end else if (cnt_reg >= DEB_CYC - 28'h1) begin
                    cnt_reg <= 28'h0;
                    lvl_reg <= keyRaw[i];
                end else begin
                    cnt_reg <= cnt_reg + 28'h1;
                end
            end
            assign keyLvl[i] = lvl_reg;
        end
    endgenerate

    // Press edges of the debounced levels
    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            keyPrev_reg <= 4'h0;
        end else begin
            keyPrev_reg <= keyLvl;
        end
    end
    assign keyPress   = keyLvl & ~keyPrev_reg;
    assign pressProg  = keyPress[0];
    assign pressUp    = keyPress[1];
    assign pressDown  = keyPress[2];
    assign pressEnter = keyPress[3];
    assign anyPress   = |keyPress;

    // First and last parameter of a group
    function [15:0] grpSpan;
        input [3:0] g;
        begin
            case (g)
                4'h1: grpSpan = `G01_SPAN;
                4'h2: grpSpan = `G02_SPAN;
                4'h3: grpSpan = `G03_SPAN;
                4'h4: grpSpan = `G04_SPAN;
                4'h5: grpSpan = `G05_SPAN;
                4'h6: grpSpan = `G06_SPAN;
                4'h7: grpSpan = `G07_SPAN;
                4'h8: grpSpan = `G08_SPAN;
                4'h9: grpSpan = `G09_SPAN;
                4'ha: grpSpan = `G10_SPAN;
                4'hb: grpSpan = `G11_SPAN;
                4'hc: grpSpan = `G12_SPAN;
                4'hd: grpSpan = `G13_SPAN;
                default: grpSpan = `G01_SPAN;
            endcase
        end
    endfunction
    assign span = grpSpan(group_reg);
    assign presetSpan = grpSpan(`PRESET_GROUP);

    // Menu read port: lock code of the group, else the current parameter
    assign rdAddr = (state_reg == `ST_GROUP || state_reg == `ST_CODE) ?
                    (`CODE_PARAM_BASE + {4'h0, group_reg}) : param_reg;

    param_store #(
        .AW (8),
        .DW (32)
    ) uStore (
        .clk       (ref_clk),
        .rstSync_n (rstSync_n),
        .wrEn      (storeNow),
        .wrAddr    (param_reg),
        .wrData    (editVal_reg),
        .rdAddr    (rdAddr),
        .rdData    (rdData),
        .cfgAddr   (cfgAddr),
        .cfgData   (cfgData)
    );

    // Idle time-out and the shared one-level-up step
    assign menuOpen = state_reg != `ST_NORMAL && state_reg != `ST_VERDICT;
    assign timeout  = menuOpen && !anyPress
                      && idle_reg >= TIMEOUT_CYC - 28'h1;
    assign upStep   = pressProg || timeout;

    // Only preset parameters may change in fast access
    assign editAllowed = !fast_reg || group_reg == `PRESET_GROUP;
    assign storeNow    = state_reg == `ST_VALUE && pressProg
                         && editAllowed;

    // Digit stepping under the cursor
    assign shiftAmt    = {cursor_reg, 2'b00};
    assign shifted     = editVal_reg >> shiftAmt;
    assign curDigit    = shifted[3:0];
    assign signedDigit = state_reg == `ST_VALUE && group_reg == `PRESET_GROUP
                         && cursor_reg == LEFT_POS;
    assign digitTop    = signedDigit ? `DIGIT_NEG_ONE : `DIGIT_MAX;
    assign digitUp     = (curDigit >= digitTop) ? 4'h0 : curDigit + 4'h1;
    assign digitDown   = (curDigit == 4'h0 || curDigit > digitTop) ?
                         digitTop : curDigit - 4'h1;
    assign digitMask   = 32'hf << shiftAmt;
    assign valUp       = (editVal_reg & ~digitMask)
                         | ({28'h0, digitUp} << shiftAmt);
    assign valDown     = (editVal_reg & ~digitMask)
                         | ({28'h0, digitDown} << shiftAmt);
    assign cursorLeft  = (cursor_reg >= LEFT_POS) ? 3'h0
                         : cursor_reg + 3'h1;

    // Idle counter restarts on every key press
    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            idle_reg <= 28'h0;
        end else if (!menuOpen || anyPress || timeout) begin
            idle_reg <= 28'h0;
        end else begin
            idle_reg <= idle_reg + 28'h1;
        end
    end

    // Key functions: pending copy on store, active copy on return
    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            fnUpPend_reg <= 8'h0;
            fnDnPend_reg <= 8'h0;
            fnEnPend_reg <= 8'h0;
            fnUpAct_reg  <= 8'h0;
            fnDnAct_reg  <= 8'h0;
            fnEnAct_reg  <= 8'h0;
        end else begin
            if (storeNow && param_reg == `KEYFN_UP_PARAM) begin
                fnUpPend_reg <= editVal_reg[7:0];
            end
            if (storeNow && param_reg == `KEYFN_DN_PARAM) begin
                fnDnPend_reg <= editVal_reg[7:0];
            end
            if (storeNow && param_reg == `KEYFN_EN_PARAM) begin
                fnEnPend_reg <= editVal_reg[7:0];
            end
            if (apply_reg) begin
                fnUpAct_reg <= fnUpPend_reg;
                fnDnAct_reg <= fnDnPend_reg;
                fnEnAct_reg <= fnEnPend_reg;
            end
        end
    end

    // Menu state machine
    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_reg     <= `ST_NORMAL;
            group_reg     <= `GROUP_FIRST;
            param_reg     <= 8'h0;
            editVal_reg   <= 32'h0;
            cursor_reg    <= 3'h0;
            fast_reg      <= 1'b0;
            hold_reg      <= 28'h0;
            verdictOk_reg <= 1'b0;
            apply_reg     <= 1'b0;
            cmdValid_reg  <= 1'b0;
            cmdSel_reg    <= 2'h0;
            cmdFunc_reg   <= 8'h0;
        end else begin
            apply_reg    <= 1'b0;
            cmdValid_reg <= 1'b0;
            case (state_reg)
                `ST_NORMAL: begin
                    if (keyLvl[1] && keyLvl[2] && (pressUp || pressDown)) begin
                        state_reg <= `ST_PARAM;
                        group_reg <= `PRESET_GROUP;
                        param_reg <= presetSpan[15:8];
                        fast_reg  <= 1'b1;
                        hold_reg  <= 28'h0;
                    end else if (keyLvl[0] && hold_reg >= LONG_CYC - 28'h1) begin
                        state_reg <= `ST_GROUP;
                        group_reg <= `GROUP_FIRST;
                        fast_reg  <= 1'b0;
                        hold_reg  <= 28'h0;
                    end else begin
                        hold_reg <= keyLvl[0] ? hold_reg + 28'h1 : 28'h0;
                        if (pressUp && !keyLvl[2]) begin
                            cmdValid_reg <= 1'b1;
                            cmdSel_reg   <= 2'h1;
                            cmdFunc_reg  <= fnUpAct_reg;
                        end else if (pressDown && !keyLvl[1]) begin
                            cmdValid_reg <= 1'b1;
                            cmdSel_reg   <= 2'h2;
                            cmdFunc_reg  <= fnDnAct_reg;
                        end else if (pressEnter) begin
                            cmdValid_reg <= 1'b1;
                            cmdSel_reg   <= 2'h3;
                            cmdFunc_reg  <= fnEnAct_reg;
                        end
                    end
                end
                `ST_GROUP: begin
                    if (upStep) begin
                        state_reg <= `ST_NORMAL;
                        apply_reg <= 1'b1;
                        fast_reg  <= 1'b0;
                    end else if (pressUp && !fast_reg) begin
                        group_reg <= (group_reg >= `GROUP_LAST) ? `GROUP_FIRST
                                     : group_reg + 4'h1;
                    end else if (pressDown && !fast_reg) begin
                        group_reg <= (group_reg <= `GROUP_FIRST) ? `GROUP_LAST
                                     : group_reg - 4'h1;
                    end else if (pressEnter) begin
                        if (rdData != 32'h0 && !fast_reg) begin
                            state_reg   <= `ST_CODE;
                            editVal_reg <= 32'h0;
                            cursor_reg  <= 3'h0;
                            hold_reg    <= 28'h0;
                        end else begin
                            state_reg <= `ST_PARAM;
                            param_reg <= span[15:8];
                        end
                    end
                end
                `ST_PARAM: begin
                    if (upStep) begin
                        state_reg <= `ST_GROUP;
                    end else if (pressUp) begin
                        param_reg <= (param_reg >= span[7:0]) ? span[15:8]
                                     : param_reg + 8'h1;
                    end else if (pressDown) begin
                        param_reg <= (param_reg <= span[15:8]) ? span[7:0]
                                     : param_reg - 8'h1;
                    end else if (pressEnter && editAllowed) begin
                        state_reg   <= `ST_VALUE;
                        editVal_reg <= rdData;
                        cursor_reg  <= 3'h0;
                    end
                end
                `ST_VALUE: begin
                    if (upStep) begin
                        state_reg <= `ST_PARAM;
                    end else if (pressUp) begin
                        editVal_reg <= valUp;
                    end else if (pressDown) begin
                        editVal_reg <= valDown;
                    end else if (pressEnter) begin
                        cursor_reg <= cursorLeft;
                    end
                end
                `ST_CODE: begin
                    if (upStep) begin
                        state_reg <= `ST_NORMAL;
                        apply_reg <= 1'b1;
                        hold_reg  <= 28'h0; // Long press restarts from zero
                    end else if (keyLvl[3] && hold_reg >= CODE_HOLD_CYC - 28'h1) begin
                        state_reg     <= `ST_VERDICT;
                        verdictOk_reg <= editVal_reg == rdData;
                        hold_reg      <= 28'h0;
                    end else begin
                        hold_reg <= keyLvl[3] ? hold_reg + 28'h1 : 28'h0;
                        if (pressUp) begin
                            editVal_reg <= valUp;
                        end else if (pressDown) begin
                            editVal_reg <= valDown;
                        end else if (pressEnter) begin
                            cursor_reg <= cursorLeft;
                        end
                    end
                end
                `ST_VERDICT: begin
                    if (hold_reg >= VERDICT_CYC - 28'h1) begin
                        hold_reg <= 28'h0;
                        if (verdictOk_reg) begin
                            state_reg <= `ST_PARAM;
                            param_reg <= span[15:8];
                        end else begin
                            state_reg <= `ST_NORMAL;
                            apply_reg <= 1'b1;
                        end
                    end else begin
                        hold_reg <= hold_reg + 28'h1;
                    end
                end
                default: begin
                    state_reg <= `ST_NORMAL;
                end
            endcase
        end
    end

    // Display mode decode
    always @* begin
        case (state_reg)
            `ST_GROUP:   dispMode = `DISP_GROUP;
            `ST_PARAM:   dispMode = `DISP_PARAM;
            `ST_VALUE:   dispMode = `DISP_VALUE;
            `ST_CODE:    dispMode = `DISP_CODE;
            `ST_VERDICT: dispMode = verdictOk_reg ? `DISP_YES : `DISP_NO;
            default:     dispMode = `DISP_COUNT;
        endcase
    end

    // Evaluation halts in general setup, runs in fast access
    assign evalEnable  = state_reg == `ST_NORMAL || fast_reg;
    assign applyPulse  = apply_reg;
    assign fastMode    = fast_reg;
    assign keyCmdValid = cmdValid_reg;
    assign keyCmdSel   = cmdSel_reg;
    assign keyCmdFunc  = cmdFunc_reg;
    assign dispGroup   = group_reg;
    assign dispParam   = param_reg;
    assign dispValue   = editVal_reg;
    assign cursorPos   = cursor_reg;
endmodule // keypad_menu_controller

`default_nettype wire

// ### rtl/keypad_menu_regs.vh
// Constants of the keypad menu controller: timing figures, parameter map,
// menu states, display modes and digit codes.
// Included by the menu controller; holds definitions only.
`ifndef KEYPAD_MENU_REGS_VH
`define KEYPAD_MENU_REGS_VH

// Clock rate and times in milliseconds, sized to the 28-bit cycle counters
`define CLK_KHZ         28'h61a8
`define LONG_PRESS_MS   28'h7d0
`define TIMEOUT_MS      28'h2710
`define DEBOUNCE_MS     28'h14
`define CODE_HOLD_MS    28'h3e8
`define VERDICT_MS      28'h3e8

// Group numbering and special parameters
`define GROUP_FIRST     4'h1
`define GROUP_LAST      4'hd
`define PRESET_GROUP    4'h1
`define CODE_PARAM_BASE 8'h64
`define KEYFN_UP_PARAM  8'h44
`define KEYFN_DN_PARAM  8'h45
`define KEYFN_EN_PARAM  8'h46

// First and last parameter number of each group
`define G01_SPAN        16'h0005
`define G02_SPAN        16'h0812
`define G03_SPAN        16'h1524
`define G04_SPAN        16'h2736
`define G05_SPAN        16'h3941
`define G06_SPAN        16'h444e
`define G07_SPAN        16'h5162
`define G08_SPAN        16'h6571
`define G09_SPAN        16'h767b
`define G10_SPAN        16'h7d82
`define G11_SPAN        16'h8788
`define G12_SPAN        16'h8baa
`define G13_SPAN        16'habca

// Leftmost digit codes of a signed value
`define DIGIT_MAX       4'h9
`define DIGIT_NEG       4'ha
`define DIGIT_NEG_ONE   4'hb

// Menu states
`define ST_NORMAL       3'h0
`define ST_GROUP        3'h1
`define ST_PARAM        3'h2
`define ST_VALUE        3'h3
`define ST_CODE         3'h4
`define ST_VERDICT      3'h5

// Display modes
`define DISP_COUNT      3'h0
`define DISP_GROUP      3'h1
`define DISP_PARAM      3'h2
`define DISP_VALUE      3'h3
`define DISP_CODE       3'h4
`define DISP_YES        3'h5
`define DISP_NO         3'h6

`endif

// ### rtl/param_store.v
// Parameter memory: one write port, two registered read ports.
// Entries never written read as zero; valid bits clear at reset.
`timescale 1ns/1ps
`default_nettype none

module param_store #(
    parameter AW = 8,
    parameter DW = 32
) (
    input  wire          clk,
    input  wire          rstSync_n,
    input  wire          wrEn,
    input  wire [AW-1:0] wrAddr,
    input  wire [DW-1:0] wrData,
    input  wire [AW-1:0] rdAddr,
    output wire [DW-1:0] rdData,
    input  wire [AW-1:0] cfgAddr,
    output wire [DW-1:0] cfgData
);
    reg [DW-1:0]        mem [0:(1<<AW)-1];
    reg [(1<<AW)-1:0]   vld_reg;
    reg [DW-1:0]        rdData_reg;
    reg [DW-1:0]        cfgData_reg;

    // Storage array
    always @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Valid bits and registered read data
    always @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            vld_reg     <= {(1<<AW){1'b0}};
            rdData_reg  <= {DW{1'b0}};
            cfgData_reg <= {DW{1'b0}};
        end else begin
            if (wrEn) begin
                vld_reg[wrAddr] <= 1'b1;
            end
            rdData_reg  <= vld_reg[rdAddr] ? mem[rdAddr] : {DW{1'b0}};
            cfgData_reg <= vld_reg[cfgAddr] ? mem[cfgAddr] : {DW{1'b0}};
        end
    end

    assign rdData  = rdData_reg;
    assign cfgData = cfgData_reg;
endmodule // param_store

`default_nettype wire

// ### sim/keypad_menu_monitor.sv
// Checker of the keypad menu controller ports.
// Bound to the controller; counts come from its own parameters.
`timescale 1ns/1ps
`default_nettype none
module keypad_menu_monitor #(
    parameter [27:0] LONG_CYC      = 40,
    parameter [27:0] TIMEOUT_CYC   = 200,
    parameter [27:0] CODE_HOLD_CYC = 20
) (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       programKey,
    input wire logic       upKey,
    input wire logic       downKey,
    input wire logic       enterKey,
    input wire logic       evalEnable,
    input wire logic       applyPulse,
    input wire logic       fastMode,
    input wire logic [2:0] dispMode,
    input wire logic [3:0] dispGroup
);
    logic [27:0] progCnt, enterCnt, quietCnt;
    // Program and enter hold lengths, cycles since a key last went down
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            progCnt <= 28'h0;
            enterCnt <= 28'h0;
            quietCnt <= 28'h0;
        end else begin
            progCnt <= programKey ? progCnt + 28'h1 : 28'h0;
            enterCnt <= enterKey ? enterCnt + 28'h1 : 28'h0;
            quietCnt <= ($rose(programKey) || $rose(upKey) || $rose(downKey)
                || $rose(enterKey)) ? 28'h0 : quietCnt + 28'h1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_open; dispMode == 3'h0 ##1 dispMode == 3'h1; endsequence
    sequence s_drop; dispMode == 3'h3 ##1 dispMode == 3'h2 && !programKey; endsequence
    sequence s_verdict; dispMode == 3'h4 ##1 dispMode inside {3'h5, 3'h6}; endsequence
    property p_long; s_open |-> progCnt >= LONG_CYC; endproperty
    a_long: assert property (p_long) else $error("setup opened early");
    property p_span; dispMode == 3'h1 |-> dispGroup inside {[4'h1:4'hd]}; endproperty
    a_span: assert property (p_span) else $error("group out of range");
    property p_hold; dispMode inside {[3'h1:3'h3]} && !fastMode |-> !evalEnable; endproperty
    a_hold: assert property (p_hold) else $error("evaluation in setup");
    property p_apply; applyPulse |=> !applyPulse && dispMode == 3'h0; endproperty
    a_apply: assert property (p_apply) else $error("apply outside normal");
    property p_run; fastMode |-> evalEnable; endproperty
    a_run: assert property (p_run) else $error("evaluation stopped");
    property p_preset; fastMode |-> dispGroup == 4'h1; endproperty
    a_preset: assert property (p_preset) else $error("fast left presets");
    property p_idle; s_drop |-> quietCnt >= TIMEOUT_CYC; endproperty
    a_idle: assert property (p_idle) else $error("early idle exit");
    property p_code; s_verdict |-> enterCnt >= CODE_HOLD_CYC; endproperty
    a_code: assert property (p_code) else $error("early verdict");
endmodule // keypad_menu_monitor
bind keypad_menu_controller keypad_menu_monitor #(.LONG_CYC(LONG_CYC),
    .TIMEOUT_CYC(TIMEOUT_CYC), .CODE_HOLD_CYC(CODE_HOLD_CYC)) u_keypad_menu_monitor (
    .ref_clk, .rst_n, .programKey, .upKey, .downKey, .enterKey,
    .evalEnable, .applyPulse, .fastMode, .dispMode, .dispGroup);
`default_nettype wire

// ### sim/key_operator.sv
// Operator model pressing the four front keys.
// Keys are active high and idle low; driven 1 ns after the clock edge.
`timescale 1ns/1ps
`default_nettype none
module key_operator #(
    parameter int DEB = 4
) (
    input  wire logic ref_clk,
    output var  logic programKey,
    output var  logic upKey,
    output var  logic downKey,
    output var  logic enterKey
);
    initial {programKey, upKey, downKey, enterKey} = 4'h0;
    // Hold the chosen keys n cycles, release, then pause
    task automatic press(input logic [3:0] m, input int n);
        @(posedge ref_clk);
        #1 {programKey, upKey, downKey, enterKey} = m;
        repeat (n) @(posedge ref_clk);
        #1 {programKey, upKey, downKey, enterKey} = 4'h0;
        repeat (3 * DEB) @(posedge ref_clk);
    endtask
endmodule // key_operator
`default_nettype wire

// ### sim/test_keypad_menu_controller.sv
// Bench of the keypad menu controller with shortened counts.
// Keys come from the operator model; one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module test_keypad_menu_controller;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] cfgAddr = 8'h00;
    wire programKey, upKey, downKey, enterKey, evalEnable, applyPulse, fastMode, keyCmdValid;
    wire [1:0] keyCmdSel;
    wire [2:0] dispMode, cursorPos;
    wire [3:0] dispGroup;
    wire [7:0] keyCmdFunc, dispParam;
    wire [31:0] cfgData, dispValue;
    int miscompares = 0;
    int tests_run = 0;
    logic [9:0] lastCmd = 10'h0;
    logic [2:0] verdict = 3'h0;
    always #20 ref_clk = ~ref_clk;
    // Latch key commands and code verdicts as they flash by
    always @(posedge ref_clk) begin
        if (keyCmdValid === 1'b1)
            lastCmd <= {keyCmdSel, keyCmdFunc};
        if (dispMode === 3'h5 || dispMode === 3'h6)
            verdict <= dispMode;
    end
    keypad_menu_controller #(.DEB_CYC(28'h4), .LONG_CYC(28'h28), .TIMEOUT_CYC(28'hc8),
        .CODE_HOLD_CYC(28'h14), .VERDICT_CYC(28'ha)) u_keypad_menu_controller (
        .ref_clk, .rst_n, .programKey, .upKey, .downKey, .enterKey, .cfgAddr, .cfgData,
        .evalEnable, .applyPulse, .fastMode, .keyCmdValid, .keyCmdSel, .keyCmdFunc,
        .dispMode, .dispGroup, .dispParam, .dispValue, .cursorPos);
    key_operator #(.DEB(4)) u_key_operator (.ref_clk, .programKey, .upKey, .downKey, .enterKey);
    task automatic chk(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hit(input logic [3:0] m, input int n = 12, input int times = 1);
        repeat (times) u_key_operator.press(m, n);
        #2;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic waitMode(input logic [2:0] m);
        for (int i = 0; i < 400 && dispMode !== m; i++) #40;
        chk("mode", 32'(m), 32'(dispMode));
        if (dispMode !== m) summarize();
    endtask
    task automatic setupEdit();
        hit(4'h4, 2);
        chk("glitch", 32'h0, 32'(lastCmd));
        hit(4'h8, 52);
        chk("setup", 32'h1, 32'(dispMode));
        chk("eval", 32'h0, 32'(evalEnable));
        hit(4'h4, 12, 18);
        chk("group", 32'h6, 32'(dispGroup));
        hit(4'h1, 12, 2);
        hit(4'h4, 12, 3);
        chk("value", 32'h3, dispValue);
        hit(4'h1, 12, 6);
        chk("cursor", 32'h0, 32'(cursorPos));
        hit(4'h8, 12, 3);
        chk("run", 32'h1, 32'(evalEnable));
        hit(4'h4);
        chk("keyfn", 32'h103, 32'(lastCmd));
        @(posedge ref_clk) #1 cfgAddr = 8'h44;
        repeat (2) @(posedge ref_clk);
        #2 chk("cfgread", 32'h3, cfgData);
        @(posedge ref_clk) #1 cfgAddr = 8'h00;
        $display("setupEdit done");
    endtask
    task automatic fastPreset();
        hit(4'h6);
        chk("fast", 32'h1, 32'(fastMode));
        chk("live", 32'h1, 32'(evalEnable));
        hit(4'h1, 12, 6);
        hit(4'h2, 12, 2);
        chk("sign", 32'h00a00000, dispValue);
        hit(4'h8, 12, 2);
        hit(4'h4);
        chk("locked", 32'h1, 32'(dispGroup));
        hit(4'h8);
        waitMode(3'h0);
        chk("stored", 32'h00a00000, cfgData);
        $display("fastPreset done");
    endtask
    task automatic idleDrop();
        hit(4'h8, 52);
        hit(4'h1, 12, 2);
        hit(4'h4);
        chk("edit", 32'h00a00001, dispValue);
        waitMode(3'h2);
        waitMode(3'h1);
        waitMode(3'h0);
        chk("discard", 32'h00a00000, cfgData);
        $display("idleDrop done");
    endtask
    task automatic codeLock();
        hit(4'h8, 52);
        hit(4'h4, 12, 7);
        hit(4'h1);
        hit(4'h4);
        hit(4'h1);
        hit(4'h4);
        hit(4'h8, 12, 3);
        hit(4'h8, 52);
        hit(4'h4);
        hit(4'h1);
        chk("prompt", 32'h4, 32'(dispMode));
        hit(4'h1, 30);
        chk("reject", 32'h6, 32'(verdict));
        waitMode(3'h0);
        hit(4'h8, 52);
        hit(4'h4);
        hit(4'h1);
        hit(4'h4);
        hit(4'h1, 30);
        chk("accept", 32'h5, 32'(verdict));
        waitMode(3'h2);
        chk("param", 32'h8, 32'(dispParam));
        hit(4'h8, 12, 2);
        $display("codeLock done");
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        setupEdit();
        fastPreset();
        idleDrop();
        codeLock();
        summarize();
    end
endmodule // test_keypad_menu_controller
`default_nettype wire
